// ---- core/fault_mon_defs.vh ----
// constants for the led channel fault monitor
`ifndef FAULT_MON_DEFS_VH
`define FAULT_MON_DEFS_VH

// ------------------------------------------------------------
// register offsets (word index = byte offset / 4)
// ------------------------------------------------------------
`define REG_CFG_ADDR       8'h04
`define REG_STATUS_ADDR    8'h1c
`define REG_FCFG_ADDR      8'h20
`define REG_FDIS_ADDR      8'h28
`define REG_IRQ_STAT_ADDR  8'h30
`define REG_IRQ_MASK_ADDR  8'h34

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
// cfg: bit0 rolloff_enable
`define CFG_ROLLOFF_BIT    0
// status: [2:0] open, [5:3] short, [6] overtemp_shutdown_flag
`define ST_OPEN_LSB        0
`define ST_SHORT_LSB       3
`define ST_OTSD_BIT        6
// fault cfg: [2:0] open delay select, [5:4] supply gate level
`define FCFG_DELAY_LSB     0
`define FCFG_GATE_LSB      4
// fault disable: [0] open detect en, [1] short detect en,
// [2] open report en, [3] short report en, [4] overtemp_report_enable
`define FDIS_OPEN_DET_BIT  0
`define FDIS_SHORT_DET_BIT 1
`define FDIS_OPEN_REP_BIT  2
`define FDIS_SHORT_REP_BIT 3
`define FDIS_OT_REP_BIT    4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CFG_RST            8'h01
`define FCFG_RST           8'h00
`define FDIS_RST           8'h1f
`define IRQ_MASK_RST       8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_HZ             25000000
`define SHORT_QUAL_MS      5
`define SHORT_QUAL_CYC     ((`CLK_HZ / 1000) * `SHORT_QUAL_MS)
// open delay step per delay code unit
`define OPEN_STEP_MS       1
`define OPEN_STEP_CYC      ((`CLK_HZ / 1000) * `OPEN_STEP_MS)

// ------------------------------------------------------------
// thermal
// ------------------------------------------------------------
`define ROLLOFF_TEMP_C     8'd145
`define SHUTDOWN_TEMP_C    8'd175
`define RESTART_TEMP_C     8'd145
// rate in tenths of a percent per degree, floor in percent
`define ROLLOFF_RATE_PM    38
`define ROLLOFF_MIN_PCT    5

`endif

// ---- core/led_channel_fault_monitor.v ----
// fault supervision for a three-channel led current driver
// Operation
// - open detection runs only while supply is above the selected gate level.
// - open fault is declared after the open comparator holds for the programmed delay.
// - on open fault the channel keeps sourcing, its open flag sets and the fault pin pulls low.
// - when the open condition goes away the open flag clears and the pin is released.
// - short fault is declared only after the short comparator holds for 5 ms.
// - on short fault the channel drops to reduced current, short flag sets, pin pulls low.
// - when the short goes away current is restored, flag clears, pin released.
// - the fault pin is open drain: released when quiet, driven low on a fault.
// - the fault-disable register can switch off open/short detection and reporting.
// - above the rolloff temperature current falls 3.8 %/degC down to 5 %, then turns off.
// - clearing the rolloff enable bit in the config register suppresses rolloff.
// - above the shutdown temperature channels turn off, shutdown flag sets, pin pulls low.
// - after shutdown every attempt to turn a channel on is blocked until below restart temp.
// - on restart the shutdown flag clears and the pin is released.
// - the overtemp report enable bit gates pin assertion for thermal shutdown.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "fault_mon_defs.vh"
module led_channel_fault_monitor #(
	parameter NCH       = 3,
	parameter TW        = 8,
	parameter CW        = 24,
	parameter SHORT_CYC = `SHORT_QUAL_CYC,
	parameter OPEN_STEP = `OPEN_STEP_CYC
) (
	// clock and reset
	input  wire           i_clk_sys,
	input  wire           i_sys_rst,
	// register port
	input  wire [7:0]     i_reg_addr,
	input  wire [7:0]     i_reg_wdata,
	input  wire           i_reg_wr,
	input  wire           i_reg_rd,
	output wire [7:0]     o_reg_rdata,
	// analog comparator results (asynchronous)
	input  wire [NCH-1:0] i_open_cmp,
	input  wire [NCH-1:0] i_short_cmp,
	input  wire [3:0]     i_supply_level,
	input  wire [TW-1:0]  i_die_temp,
	// channel requests
	input  wire [NCH-1:0] i_chan_on_req,
	// channel drive
	output wire [NCH-1:0] o_channel_output_en,
	output wire [NCH-1:0] o_channel_reduced,
	output wire [6:0]     o_rolloff_scale_pct,
	// fault pin, open drain
	output wire           o_fault_out_n,
	output wire           o_fault_out_n_oe,
	// interrupt
	output wire           o_irq
);
	// ------------------------------------------------------------
	// synchronised inputs
	// ------------------------------------------------------------
	wire [NCH-1:0] open_s;
	wire [NCH-1:0] short_s;
	wire [3:0]     supply_s;
	wire [TW-1:0]  temp_s;
	wire [NCH-1:0] req_s;

	sync2 #(.W(3*NCH + 4 + TW)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_async   ({i_open_cmp, i_short_cmp, i_supply_level, i_die_temp, i_chan_on_req}),
		.o_sync    ({open_s, short_s, supply_s, temp_s, req_s})
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] cfg_ff;
	reg [7:0] fcfg_ff;
	reg [7:0] fdis_ff;
	reg [7:0] irq_stat_ff;
	reg [7:0] irq_mask_ff;
	reg [7:0] rdata_ff;
	reg [7:0] nxt_rdata;

	wire rolloff_enable = cfg_ff[`CFG_ROLLOFF_BIT];
	wire open_det_en    = fdis_ff[`FDIS_OPEN_DET_BIT];
	wire short_det_en   = fdis_ff[`FDIS_SHORT_DET_BIT];
	wire open_rep_en    = fdis_ff[`FDIS_OPEN_REP_BIT];
	wire short_rep_en   = fdis_ff[`FDIS_SHORT_REP_BIT];
	wire overtemp_report_enable = fdis_ff[`FDIS_OT_REP_BIT];
	wire [1:0] detect_supply_gate_level = fcfg_ff[`FCFG_GATE_LSB +: 2];
	wire [2:0] open_delay_sel = fcfg_ff[`FCFG_DELAY_LSB +: 3];

	function wr_hit;
		input [7:0] a;
		begin
			wr_hit = i_reg_wr && (i_reg_addr == a);
		end
	endfunction

	// ------------------------------------------------------------
	// open and short qualification
	// ------------------------------------------------------------
	// supply gate level code n needs supply above n*4 (of 16)
	wire supply_ok = (supply_s > {detect_supply_gate_level, 2'b00});
	wire [CW-1:0] open_limit;
	wire [NCH-1:0] open_q;
	wire [NCH-1:0] short_q;

	// delay code 0 means one step; each code adds a step
	localparam [CW-1:0] OPEN_STEP_W = OPEN_STEP[CW-1:0];
	assign open_limit = OPEN_STEP_W * ({{(CW-3){1'b0}}, open_delay_sel} + 1'b1);

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			qual_timer #(.CW(CW)) u_open (
				.i_clk_sys (i_clk_sys),
				.i_sys_rst (i_sys_rst),
				.i_cond    (open_s[g] & open_det_en & supply_ok),
				.i_limit   (open_limit),
				.o_qual    (open_q[g])
			);
			qual_timer #(.CW(CW)) u_short (
				.i_clk_sys (i_clk_sys),
				.i_sys_rst (i_sys_rst),
				.i_cond    (short_s[g] & short_det_en),
				.i_limit   (SHORT_CYC[CW-1:0]),
				.o_qual    (short_q[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// thermal shutdown with restart lockout
	// ------------------------------------------------------------
	reg otsd_ff;
	wire [TW-1:0] shutdown_t = `SHUTDOWN_TEMP_C;
	wire [TW-1:0] restart_t  = `RESTART_TEMP_C;
	wire [TW-1:0] rolloff_t  = `ROLLOFF_TEMP_C;

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			otsd_ff <= 1'b0;
		end else if (temp_s > shutdown_t) begin
			otsd_ff <= 1'b1;
		end else if (otsd_ff && temp_s < restart_t) begin
			otsd_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// thermal rolloff
	// ------------------------------------------------------------
	reg  [6:0]  scale_ff;
	reg  [6:0]  nxt_scale;
	reg  [15:0] drop_pm;
	reg  [15:0] drop_pct;
	reg  [TW-1:0] over_t;
	reg         roll_off_ff;

	always @* begin
		over_t    = temp_s - rolloff_t;
		drop_pm   = {{(16-TW){1'b0}}, over_t} * 16'd`ROLLOFF_RATE_PM;
		drop_pct  = drop_pm / 16'd10;
		nxt_scale = 7'd100;
		if (rolloff_enable && temp_s > rolloff_t) begin
			if (drop_pm >= 16'd1000 - 16'd10 * `ROLLOFF_MIN_PCT)
				nxt_scale = 7'd0;
			else
				nxt_scale = 7'd100 - drop_pct[6:0];
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			scale_ff    <= 7'd100;
			roll_off_ff <= 1'b0;
		end else begin
			scale_ff    <= nxt_scale;
			roll_off_ff <= (nxt_scale == 7'd0);
		end
	end

	// ------------------------------------------------------------
	// channel drive
	// ------------------------------------------------------------
	reg [NCH-1:0] en_ff;
	reg [NCH-1:0] red_ff;

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			en_ff  <= {NCH{1'b0}};
			red_ff <= {NCH{1'b0}};
		end else begin
			// open keeps sourcing; shutdown blocks any turn-on
			en_ff  <= (otsd_ff || roll_off_ff) ? {NCH{1'b0}} : req_s;
			red_ff <= short_q;
		end
	end

	// ------------------------------------------------------------
	// status and fault pin
	// ------------------------------------------------------------
	wire [6:0] status = {otsd_ff, short_q, open_q};
	reg        fault_ff;

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			fault_ff <= 1'b0;
		end else begin
			fault_ff <= (open_rep_en && |open_q) ||
			            (short_rep_en && |short_q) ||
			            (overtemp_report_enable && otsd_ff);
		end
	end

	// open drain: drive low only, otherwise release
	assign o_fault_out_n    = 1'b0;
	assign o_fault_out_n_oe = fault_ff;

	// ------------------------------------------------------------
	// interrupt and register access
	// ------------------------------------------------------------
	reg  [6:0] status_d_ff;
	wire [6:0] rise = status & ~status_d_ff;

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cfg_ff      <= `CFG_RST;
			fcfg_ff     <= `FCFG_RST;
			fdis_ff     <= `FDIS_RST;
			irq_mask_ff <= `IRQ_MASK_RST;
			irq_stat_ff <= 8'h00;
			status_d_ff <= 7'h00;
			rdata_ff    <= 8'h00;
		end else begin
			status_d_ff <= status;
			rdata_ff    <= nxt_rdata;
			if (wr_hit(`REG_CFG_ADDR))
				cfg_ff <= i_reg_wdata;
			if (wr_hit(`REG_FCFG_ADDR))
				fcfg_ff <= i_reg_wdata;
			if (wr_hit(`REG_FDIS_ADDR))
				fdis_ff <= i_reg_wdata;
			if (wr_hit(`REG_IRQ_MASK_ADDR))
				irq_mask_ff <= i_reg_wdata;
			// set wins over write-one-to-clear
			irq_stat_ff <= (irq_stat_ff &
				~(wr_hit(`REG_IRQ_STAT_ADDR) ? i_reg_wdata : 8'h00)) | {1'b0, rise};
		end
	end

	always @* begin
		nxt_rdata = 8'h00;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`REG_CFG_ADDR:      nxt_rdata = cfg_ff;
				`REG_STATUS_ADDR:   nxt_rdata = {1'b0, status};
				`REG_FCFG_ADDR:     nxt_rdata = fcfg_ff;
				`REG_FDIS_ADDR:     nxt_rdata = fdis_ff;
				`REG_IRQ_STAT_ADDR: nxt_rdata = irq_stat_ff;
				`REG_IRQ_MASK_ADDR: nxt_rdata = irq_mask_ff;
				default:            nxt_rdata = 8'h00;
			endcase
		end
	end

	assign o_reg_rdata         = rdata_ff;
	assign o_irq               = |(irq_stat_ff & irq_mask_ff);
	assign o_channel_output_en = en_ff;
	assign o_channel_reduced   = red_ff;
	assign o_rolloff_scale_pct = scale_ff;
endmodule // led_channel_fault_monitor

// ---- core/qual_timer.v ----
// qualification timer: flags after a condition has held for a count
`timescale 1ns/1ps
module qual_timer #(
	parameter CW = 24
) (
	// clock and reset
	input  wire          i_clk_sys,
	input  wire          i_sys_rst,
	// condition and limit
	input  wire          i_cond,
	input  wire [CW-1:0] i_limit,
	output wire          o_qual
);
	reg [CW-1:0] cnt_ff;
	reg          qual_ff;

	// counter restarts whenever the condition drops
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cnt_ff  <= {CW{1'b0}};
			qual_ff <= 1'b0;
		end else if (!i_cond) begin
			cnt_ff  <= {CW{1'b0}};
			qual_ff <= 1'b0;
		end else if (cnt_ff + 1'b1 >= i_limit) begin
			qual_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign o_qual = qual_ff;
endmodule // qual_timer

// ---- core/sync2.v ----
// two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sync2 #(
	parameter W = 1
) (
	// clock and reset
	input  wire         i_clk_sys,
	input  wire         i_sys_rst,
	// data
	input  wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule // sync2

// ---- tb/fault_mon_monitor.sv ----
// port assertions for the led channel fault monitor
`timescale 1ns/1ps
module fault_mon_monitor #(
	parameter NCH       = 3,
	parameter TW        = 8,
	parameter CW        = 24,
	parameter SHORT_CYC = 8,
	parameter OPEN_STEP = 4
) (
	// clock and reset
	input wire           i_clk_sys,
	input wire           i_sys_rst,
	// register port
	input wire [7:0]     i_reg_addr,
	input wire [7:0]     i_reg_wdata,
	input wire           i_reg_wr,
	input wire           i_reg_rd,
	input wire [7:0]     o_reg_rdata,
	// analog side
	input wire [NCH-1:0] i_open_cmp,
	input wire [NCH-1:0] i_short_cmp,
	input wire [3:0]     i_supply_level,
	input wire [TW-1:0]  i_die_temp,
	input wire [NCH-1:0] i_chan_on_req,
	// outputs
	input wire [NCH-1:0] o_channel_output_en,
	input wire [NCH-1:0] o_channel_reduced,
	input wire [6:0]     o_rolloff_scale_pct,
	input wire           o_fault_out_n,
	input wire           o_fault_out_n_oe,
	input wire           o_irq
);
	reg [CW-1:0] short_run_ff;
	reg          hot_ff;
	wire         cause = (|i_open_cmp) || (|i_short_cmp) || (i_die_temp > 8'd175);

	// ------------------------------------------------------------
	// helpers: raw short run length, shutdown lockout span
	// ------------------------------------------------------------
	always @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			short_run_ff <= {CW{1'b0}};
			hot_ff <= 1'b0;
		end else begin
			short_run_ff <= i_short_cmp[0] ? short_run_ff + 1'b1 : {CW{1'b0}};
			if (i_die_temp > 8'd175)
				hot_ff <= 1'b1;
			else if (i_die_temp < 8'd145)
				hot_ff <= 1'b0;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	AST_PIN_LOW: assert property (o_fault_out_n == 1'b0)
		else $error("fault pin drive value not low");
	AST_RDATA_IDLE: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
		else $error("read data outside its slot");
	AST_SHORT_QUAL: assert property ($rose(o_channel_reduced[0]) |-> short_run_ff >= SHORT_CYC)
		else $error("short declared too early");
	AST_SHORT_REL: assert property ((!i_short_cmp[0]) [*6] |-> !o_channel_reduced[0])
		else $error("reduced current kept after short gone");
	AST_TSD_OFF: assert property ((i_die_temp > 8'd175) [*6] |-> o_channel_output_en == {NCH{1'b0}})
		else $error("channels on above shutdown level");
	AST_TSD_LOCK: assert property ($rose(o_channel_output_en[0]) |-> !(hot_ff && $past(hot_ff, 4)))
		else $error("channel restarted while locked out");
	AST_SCALE_FULL: assert property ((i_die_temp <= 8'd145) [*6] |-> o_rolloff_scale_pct == 7'd100)
		else $error("scale reduced below rolloff level");
	AST_OE_CAUSE: assert property ($rose(o_fault_out_n_oe) |-> $past(cause, 4) || $past(cause, 5))
		else $error("fault pin pulled without a fault");
endmodule // fault_mon_monitor

bind led_channel_fault_monitor fault_mon_monitor #(.NCH(NCH), .TW(TW), .CW(CW),
	.SHORT_CYC(SHORT_CYC), .OPEN_STEP(OPEN_STEP)) u_mon (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_open_cmp(i_open_cmp), .i_short_cmp(i_short_cmp), .i_supply_level(i_supply_level),
	.i_die_temp(i_die_temp), .i_chan_on_req(i_chan_on_req),
	.o_channel_output_en(o_channel_output_en), .o_channel_reduced(o_channel_reduced),
	.o_rolloff_scale_pct(o_rolloff_scale_pct), .o_fault_out_n(o_fault_out_n),
	.o_fault_out_n_oe(o_fault_out_n_oe), .o_irq(o_irq));

// ---- tb/host_fault_watch.sv ----
// host side view of the open-drain fault pin
`timescale 1ns/1ps
module host_fault_watch (
	// pin drive from the block
	input  wire i_pin_drive,
	input  wire i_pin_drive_oe,
	// level seen by the host
	output wire o_pin_level
);
	// pull-up wins while the block lets go
	assign o_pin_level = i_pin_drive_oe ? i_pin_drive : 1'b1;
endmodule // host_fault_watch

// ---- tb/testbench.sv ----
// self-checking bench for the led channel fault monitor
`timescale 1ns/1ps
`include "fault_mon_defs.vh"
module testbench;
	logic        i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd;
	logic [7:0]  i_reg_addr, i_reg_wdata, i_die_temp;
	logic [2:0]  i_open_cmp, i_short_cmp, i_chan_on_req;
	logic [3:0]  i_supply_level;
	wire  [7:0]  o_reg_rdata;
	wire  [2:0]  en, red;
	wire  [6:0]  scale;
	wire         drv, oe, o_irq, pin;
	int          n_mismatch = 0;
	int          checks = 0;
	logic [15:0] rows [0:6];

	led_channel_fault_monitor #(.SHORT_CYC(8), .OPEN_STEP(4)) dut (.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.i_open_cmp(i_open_cmp), .i_short_cmp(i_short_cmp), .i_supply_level(i_supply_level),
		.i_die_temp(i_die_temp), .i_chan_on_req(i_chan_on_req), .o_channel_output_en(en),
		.o_channel_reduced(red), .o_rolloff_scale_pct(scale), .o_fault_out_n(drv),
		.o_fault_out_n_oe(oe), .o_irq(o_irq));
	host_fault_watch host (.i_pin_drive(drv), .i_pin_drive_oe(oe), .o_pin_level(pin));

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1 chk(name, exp, o_reg_rdata);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic print_verdict;
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_mismatch++;
		print_verdict();
	end

	initial begin
		{i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, i_open_cmp, i_short_cmp} = '0;
		i_sys_rst = 1'b1;
		i_supply_level = 4'hf;
		i_die_temp = 8'd25;
		i_chan_on_req = 3'b111;
		rows = '{16'h0401, 16'h1c00, 16'h2000, 16'h281f, 16'h3000, 16'h3400, 16'h0800};
		repeat (5) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		foreach (rows[i]) rd_chk("reg", rows[i][15:8], rows[i][7:0]);
		chk("en", 8'h07, {5'b0, en});
		chk("scale", 8'd100, {1'b0, scale});
		// ------------------------------------------------------------
		// short on channel 0, with interrupt
		// ------------------------------------------------------------
		wr(`REG_IRQ_MASK_ADDR, 8'h08);
		@(posedge i_clk_sys) i_short_cmp <= 3'b001;
		cyc(6);
		chk("reduced", 8'h00, {5'b0, red});
		cyc(14);
		chk("reduced", 8'h01, {5'b0, red});
		chk("pin", 8'h00, {7'b0, pin});
		chk("irq", 8'h01, {7'b0, o_irq});
		rd_chk("status", `REG_STATUS_ADDR, 8'h08);
		@(posedge i_clk_sys) i_short_cmp <= 3'b000;
		cyc(8);
		chk("reduced", 8'h00, {5'b0, red});
		chk("pin", 8'h01, {7'b0, pin});
		rd_chk("status", `REG_STATUS_ADDR, 8'h00);
		wr(`REG_IRQ_STAT_ADDR, 8'h08);
		cyc(1);
		chk("irq", 8'h00, {7'b0, o_irq});
		// ------------------------------------------------------------
		// detection off, then reporting off
		// ------------------------------------------------------------
		wr(`REG_FDIS_ADDR, 8'h1d);
		@(posedge i_clk_sys) i_short_cmp <= 3'b100;
		cyc(20);
		rd_chk("status", `REG_STATUS_ADDR, 8'h00);
		wr(`REG_FDIS_ADDR, 8'h17);
		cyc(20);
		rd_chk("status", `REG_STATUS_ADDR, 8'h20);
		chk("pin", 8'h01, {7'b0, pin});
		@(posedge i_clk_sys) i_short_cmp <= 3'b000;
		cyc(8);
		wr(`REG_FDIS_ADDR, 8'h1f);
		// ------------------------------------------------------------
		// open on channel 1, then supply gating
		// ------------------------------------------------------------
		@(posedge i_clk_sys) i_open_cmp <= 3'b010;
		cyc(3);
		chk("pin", 8'h01, {7'b0, pin});
		cyc(10);
		chk("pin", 8'h00, {7'b0, pin});
		chk("en", 8'h07, {5'b0, en});
		rd_chk("status", `REG_STATUS_ADDR, 8'h02);
		@(posedge i_clk_sys) i_open_cmp <= 3'b000;
		cyc(8);
		chk("pin", 8'h01, {7'b0, pin});
		rd_chk("status", `REG_STATUS_ADDR, 8'h00);
		wr(`REG_FCFG_ADDR, 8'h30);
		i_supply_level <= 4'd4;
		i_open_cmp <= 3'b010;
		cyc(20);
		rd_chk("status", `REG_STATUS_ADDR, 8'h00);
		@(posedge i_clk_sys) i_supply_level <= 4'hf;
		cyc(12);
		rd_chk("status", `REG_STATUS_ADDR, 8'h02);
		@(posedge i_clk_sys) i_open_cmp <= 3'b000;
		cyc(8);
		// ------------------------------------------------------------
		// shutdown unreported, lockout, restart, then reported
		// ------------------------------------------------------------
		wr(`REG_FDIS_ADDR, 8'h0f);
		i_die_temp <= 8'd180;
		cyc(8);
		chk("en", 8'h00, {5'b0, en});
		chk("pin", 8'h01, {7'b0, pin});
		rd_chk("status", `REG_STATUS_ADDR, 8'h40);
		@(posedge i_clk_sys) i_die_temp <= 8'd160;
		cyc(8);
		chk("en", 8'h00, {5'b0, en});
		@(posedge i_clk_sys) i_die_temp <= 8'd140;
		cyc(8);
		chk("en", 8'h07, {5'b0, en});
		rd_chk("status", `REG_STATUS_ADDR, 8'h00);
		wr(`REG_FDIS_ADDR, 8'h1f);
		i_die_temp <= 8'd180;
		cyc(8);
		chk("pin", 8'h00, {7'b0, pin});
		@(posedge i_clk_sys) i_die_temp <= 8'd140;
		cyc(8);
		chk("pin", 8'h01, {7'b0, pin});
		// ------------------------------------------------------------
		// rolloff slope, floor and disable
		// ------------------------------------------------------------
		@(posedge i_clk_sys) i_die_temp <= 8'd150;
		cyc(8);
		chk("scale", 8'd81, {1'b0, scale});
		@(posedge i_clk_sys) i_die_temp <= 8'd170;
		cyc(8);
		chk("en", 8'h00, {5'b0, en});
		wr(`REG_CFG_ADDR, 8'h00);
		cyc(8);
		chk("scale", 8'd100, {1'b0, scale});
		print_verdict();
	end
endmodule // testbench
